// File: rtl/cfec_map.svh
// Operation
// - An output current above the overcurrent threshold shuts the stage down and enters the configured retry or latch-off recovery.
// - In retry mode each shutdown is followed by a restart attempt, repeated as long as the fault persists.
// - In latch-off mode the stage stays off until power is cycled or the primary enable is held off for one second.
// - The overcurrent threshold and mode are software writable and the mode resets to retry.
// - An output voltage above the overvoltage threshold shuts down, then retries or latches off as configured.
// - The overvoltage threshold and mode are software writable and the mode resets to retry.
// - Over-temperature shuts down; auto-recovery restarts once the reading is back in limits, latch mode stays off.
// - The over-temperature threshold and mode are software writable and the mode resets to its default.
// - The primary enable supports active-low and active-high polarity.
// - Primary enable level changes shorter than 120 us are ignored.
// - The primary enable polarity is software selectable.
// - The secondary enable pin is ignored after reset and can be made an input of either polarity.
`ifndef CFEC_MAP_SVH
`define CFEC_MAP_SVH
`define CFEC_ADDR_CTRL     4'h0
`define CFEC_ADDR_OC_THR   4'h1
`define CFEC_ADDR_OV_THR   4'h2
`define CFEC_ADDR_OT_THR   4'h3
`define CFEC_ADDR_STATUS   4'h4
`define CFEC_ADDR_IRQ_STS  4'h5
`define CFEC_ADDR_IRQ_CLR  4'h6
`define CFEC_ADDR_IRQ_EN   4'h7
`define CFEC_CTRL_OC_LATCH 0
`define CFEC_CTRL_OV_LATCH 1
`define CFEC_CTRL_OT_LATCH 2
`define CFEC_CTRL_PRI_POL  3
`define CFEC_CTRL_SEC_USE  4
`define CFEC_CTRL_SEC_POL  5
`define CFEC_CTRL_RST      6'h00
`define CFEC_OC_THR_RST    16'h02a0
`define CFEC_OV_THR_RST    16'he000
`define CFEC_OT_THR_RST    16'h01f4
`define CFEC_CLK_MHZ       250
`define CFEC_FILT_NS       120000
`define CFEC_FILT_CYC      ((`CFEC_FILT_NS * `CFEC_CLK_MHZ + 999) / 1000)
`define CFEC_UNLATCH_MS    1000
`define CFEC_UNLATCH_CYC   (`CFEC_UNLATCH_MS * 1000 * `CFEC_CLK_MHZ)
`define CFEC_HICCUP_US     100
`define CFEC_HICCUP_CYC    (`CFEC_HICCUP_US * `CFEC_CLK_MHZ)
`define CFEC_IRQ_OC        0
`define CFEC_IRQ_OV        1
`define CFEC_IRQ_OT        2
`define CFEC_IRQ_EN_CHG    3
`endif

// File: rtl/cfec_pkg.sv
package cfec_pkg;
  typedef enum logic [1:0] {
    CFEC_OFF   = 2'b00,
    CFEC_RUN   = 2'b01,
    CFEC_WAIT  = 2'b11,
    CFEC_LATCH = 2'b10
  } cfec_state_e;
endpackage : cfec_pkg

// File: rtl/cfec_top.sv
`include "cfec_map.svh"

module cfec_top #(
  parameter int unsigned FILT_CYC    = `CFEC_FILT_CYC,
  parameter int unsigned UNLATCH_CYC = `CFEC_UNLATCH_CYC,
  parameter int unsigned HICCUP_CYC  = `CFEC_HICCUP_CYC
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Measurements, same clock
  input  wire logic [15:0] iout_meas_i,
  input  wire logic [15:0] vout_meas_i,
  input  wire logic [15:0] temp_meas_i,
  // Enable pins, asynchronous
  input  wire logic        primary_enable_pin_i,
  input  wire logic        secondary_enable_pin_i,
  // Power stage and interrupt
  output logic             stage_run_o,
  output logic             irq_o
);

  logic [5:0]  ctrl_ff;
  logic [15:0] oc_thr_ff;
  logic [15:0] ov_thr_ff;
  logic [15:0] ot_thr_ff;
  logic [3:0]  irq_sts_ff;
  logic [3:0]  irq_en_ff;
  logic [15:0] reg_rdata_ff;
  logic        stage_run_ff;
  logic        irq_ff;
  logic [1:0]  pri_sync_ff;
  logic [1:0]  sec_sync_ff;
  logic        pri_filt_ff;
  logic [31:0] filt_cnt_ff;
  logic        pri_on_d_ff;
  logic [31:0] off_cnt_ff;
  logic [31:0] hic_cnt_ff;
  cfec_pkg::cfec_state_e state_ff;
  cfec_pkg::cfec_state_e nxt_state;
  logic        pri_on;
  logic        sec_on;
  logic        enable_ok;
  logic        oc_flt;
  logic        ov_flt;
  logic        ot_flt;
  logic        any_flt;
  logic        latch_req;
  logic        unlatch;
  logic        wr_ctrl;
  logic [3:0]  irq_evt;
  logic [15:0] nxt_rdata;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == `CFEC_ADDR_CTRL);

  // Configuration; modes reset to retry / auto-recovery
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_ff   <= `CFEC_CTRL_RST;
      oc_thr_ff <= `CFEC_OC_THR_RST;
      ov_thr_ff <= `CFEC_OV_THR_RST;
      ot_thr_ff <= `CFEC_OT_THR_RST;
    end else if (reg_wr_i) begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata_i[5:0];
      end
      if (reg_addr_i == `CFEC_ADDR_OC_THR) begin
        oc_thr_ff <= reg_wdata_i;
      end
      if (reg_addr_i == `CFEC_ADDR_OV_THR) begin
        ov_thr_ff <= reg_wdata_i;
      end
      if (reg_addr_i == `CFEC_ADDR_OT_THR) begin
        ot_thr_ff <= reg_wdata_i;
      end
    end
  end

  // Two-flop synchronisers for the pins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pri_sync_ff <= 2'h0;
      sec_sync_ff <= 2'h0;
    end else begin
      pri_sync_ff <= {pri_sync_ff[0], primary_enable_pin_i};
      sec_sync_ff <= {sec_sync_ff[0], secondary_enable_pin_i};
    end
  end

  // Level must stand FILT_CYC cycles before it is accepted
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pri_filt_ff <= 1'b0;
      filt_cnt_ff <= 32'h0;
    end else if (pri_sync_ff[1] == pri_filt_ff) begin
      filt_cnt_ff <= 32'h0;
    end else if (filt_cnt_ff >= FILT_CYC - 1) begin
      pri_filt_ff <= pri_sync_ff[1];
      filt_cnt_ff <= 32'h0;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + 32'h1;
    end
  end

  // Polarity bit set selects active-high
  assign pri_on = ctrl_ff[`CFEC_CTRL_PRI_POL] ? pri_filt_ff
                                              : ~pri_filt_ff;
  assign sec_on = ~ctrl_ff[`CFEC_CTRL_SEC_USE] ||
                  (ctrl_ff[`CFEC_CTRL_SEC_POL] ? sec_sync_ff[1]
                                               : ~sec_sync_ff[1]);
  assign enable_ok = pri_on && sec_on;

  assign oc_flt  = iout_meas_i > oc_thr_ff;
  assign ov_flt  = vout_meas_i > ov_thr_ff;
  assign ot_flt  = temp_meas_i > ot_thr_ff;
  assign any_flt = oc_flt || ov_flt || ot_flt;
  assign latch_req = (oc_flt && ctrl_ff[`CFEC_CTRL_OC_LATCH]) ||
                     (ov_flt && ctrl_ff[`CFEC_CTRL_OV_LATCH]) ||
                     (ot_flt && ctrl_ff[`CFEC_CTRL_OT_LATCH]);

  // Off time counter for unlatching; reaches full count once
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      off_cnt_ff  <= 32'h0;
      // Matches pri_on out of reset, so no false enable-change event
      pri_on_d_ff <= 1'b1;
    end else begin
      pri_on_d_ff <= pri_on;
      if (pri_on) begin
        off_cnt_ff <= 32'h0;
      end else if (off_cnt_ff < UNLATCH_CYC) begin
        off_cnt_ff <= off_cnt_ff + 32'h1;
      end
    end
  end
  // Unlatch on turn-on after a full second off
  assign unlatch = pri_on && !pri_on_d_ff &&
                   (off_cnt_ff >= UNLATCH_CYC);

  // Hiccup off-time before a restart attempt
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hic_cnt_ff <= 32'h0;
    end else if (state_ff == cfec_pkg::CFEC_WAIT) begin
      // Saturates so a long thermal wait cannot wrap the count
      if (hic_cnt_ff < HICCUP_CYC) begin
        hic_cnt_ff <= hic_cnt_ff + 32'h1;
      end
    end else begin
      hic_cnt_ff <= 32'h0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cfec_pkg::CFEC_OFF: begin
        if (enable_ok && !any_flt) begin
          nxt_state = cfec_pkg::CFEC_RUN;
        end
      end
      cfec_pkg::CFEC_RUN: begin
        if (latch_req) begin
          nxt_state = cfec_pkg::CFEC_LATCH;
        end else if (any_flt) begin
          nxt_state = cfec_pkg::CFEC_WAIT;
        end else if (!enable_ok) begin
          nxt_state = cfec_pkg::CFEC_OFF;
        end
      end
      cfec_pkg::CFEC_WAIT: begin
        // Temperature waits for the reading to clear, others time out
        if (latch_req) begin
          nxt_state = cfec_pkg::CFEC_LATCH;
        end else if (!enable_ok) begin
          nxt_state = cfec_pkg::CFEC_OFF;
        end else if (hic_cnt_ff >= HICCUP_CYC - 1 && !ot_flt) begin
          // Restart attempt; a standing fault trips it again
          nxt_state = cfec_pkg::CFEC_RUN;
        end
      end
      cfec_pkg::CFEC_LATCH: begin
        if (unlatch) begin
          nxt_state = cfec_pkg::CFEC_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff     <= cfec_pkg::CFEC_OFF;
      stage_run_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      stage_run_ff <= (nxt_state == cfec_pkg::CFEC_RUN);
    end
  end

  // Events: fault trips and accepted enable changes
  assign irq_evt[`CFEC_IRQ_OC]     = (state_ff == cfec_pkg::CFEC_RUN) && oc_flt;
  assign irq_evt[`CFEC_IRQ_OV]     = (state_ff == cfec_pkg::CFEC_RUN) && ov_flt;
  assign irq_evt[`CFEC_IRQ_OT]     = (state_ff == cfec_pkg::CFEC_RUN) && ot_flt;
  assign irq_evt[`CFEC_IRQ_EN_CHG] = pri_on != pri_on_d_ff;

  // Set wins over a same-cycle clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_sts_ff <= 4'h0;
      irq_en_ff  <= 4'h0;
      irq_ff     <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `CFEC_ADDR_IRQ_CLR) begin
        irq_sts_ff <= (irq_sts_ff & ~reg_wdata_i[3:0]) | irq_evt;
      end else begin
        irq_sts_ff <= irq_sts_ff | irq_evt;
      end
      if (reg_wr_i && reg_addr_i == `CFEC_ADDR_IRQ_EN) begin
        irq_en_ff <= reg_wdata_i[3:0];
      end
      irq_ff <= |(irq_sts_ff & irq_en_ff);
    end
  end

  always_comb begin
    nxt_rdata = 16'h0;
    unique case (reg_addr_i)
      `CFEC_ADDR_CTRL:    nxt_rdata = {10'h0, ctrl_ff};
      `CFEC_ADDR_OC_THR:  nxt_rdata = oc_thr_ff;
      `CFEC_ADDR_OV_THR:  nxt_rdata = ov_thr_ff;
      `CFEC_ADDR_OT_THR:  nxt_rdata = ot_thr_ff;
      `CFEC_ADDR_STATUS:  nxt_rdata = {8'h0, stage_run_ff, pri_on, sec_on,
                                       ot_flt, ov_flt, oc_flt, state_ff};
      `CFEC_ADDR_IRQ_STS: nxt_rdata = {12'h0, irq_sts_ff};
      `CFEC_ADDR_IRQ_EN:  nxt_rdata = {12'h0, irq_en_ff};
      default:            nxt_rdata = 16'h0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_ff <= 16'h0;
    end else if (reg_rd_i) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 16'h0;
    end
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign stage_run_o = stage_run_ff;
  assign irq_o       = irq_ff;

endmodule : cfec_top

// File: tb/cfec_onoff_switch.sv
module cfec_onoff_switch (
  input  wire logic closed_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open collector to the return; pull-up holds an open switch high
  assign pin_o = closed_i ? 1'b0 : 1'b1;
endmodule : cfec_onoff_switch

// File: tb/cfec_top_checker.sv
`include "cfec_map.svh"
module cfec_top_checker #(
  parameter int unsigned FILT_CYC = 20
) (
  input wire logic        clock_i, rst_i, reg_wr_i, reg_rd_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o,
  input wire logic [15:0] iout_meas_i, vout_meas_i, temp_meas_i,
  input wire logic        primary_enable_pin_i, secondary_enable_pin_i,
  input wire logic        stage_run_o, irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] oc_ff, ov_ff, ot_ff;
  logic [5:0]  ctl_ff;
  logic [3:0]  en_ff;
  logic [31:0] cnt_ff, age_ff;
  logic        last_ff;
  // Shadow of the configuration the design should hold
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oc_ff  <= `CFEC_OC_THR_RST;
      ov_ff  <= `CFEC_OV_THR_RST;
      ot_ff  <= `CFEC_OT_THR_RST;
      ctl_ff <= `CFEC_CTRL_RST;
      en_ff  <= 4'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `CFEC_ADDR_CTRL:   ctl_ff <= reg_wdata_i[5:0];
        `CFEC_ADDR_OC_THR: oc_ff  <= reg_wdata_i;
        `CFEC_ADDR_OV_THR: ov_ff  <= reg_wdata_i;
        `CFEC_ADDR_OT_THR: ot_ff  <= reg_wdata_i;
        `CFEC_ADDR_IRQ_EN: en_ff  <= reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end
  // Pin stability and age since reset; early run after reset is exempt
  always_ff @(posedge clock_i) begin
    last_ff <= primary_enable_pin_i;
    if (rst_i) begin
      cnt_ff <= 32'h0;
      age_ff <= 32'h0;
    end else begin
      cnt_ff <= (primary_enable_pin_i != last_ff) ? 32'h0 : cnt_ff + 32'h1;
      age_ff <= age_ff + 32'h1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence pri_held;
    (primary_enable_pin_i ^ ctl_ff[3]) && cnt_ff >= FILT_CYC + 4
      && age_ff > FILT_CYC + 8;
  endsequence
  sequence sec_held;
    ctl_ff[4] && (secondary_enable_pin_i ^ ctl_ff[5]);
  endsequence
  a_oc_trip_off: assert property (
    stage_run_o && iout_meas_i > oc_ff |-> ##[1:3] !stage_run_o)
    else $error("overcurrent left stage running");
  a_ov_trip_off: assert property (
    stage_run_o && vout_meas_i > ov_ff |-> ##[1:3] !stage_run_o)
    else $error("overvoltage left stage running");
  a_ot_trip_off: assert property (
    stage_run_o && temp_meas_i > ot_ff |-> ##[1:3] !stage_run_o)
    else $error("overtemperature left stage running");
  a_pri_off_stop: assert property (pri_held [*4] |-> !stage_run_o)
    else $error("stage runs with primary off");
  a_sec_off_stop: assert property (sec_held [*6] |-> !stage_run_o)
    else $error("stage runs with secondary off");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !stage_run_o && !irq_o && reg_rdata_o == 16'h0000)
    else $error("outputs active after reset");
  a_irq_masked: assert property ((en_ff == 4'h0) [*2] |-> !irq_o)
    else $error("interrupt with all sources masked");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data without read strobe");
endmodule : cfec_top_checker

// File: tb/tb_converter_fault_enable_ctrl.sv
`include "cfec_map.svh"
module tb_converter_fault_enable_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, rst_i, wr_s, rd_s, pri_sw, sec_sw, pri_pin, sec_pin;
  logic        run, irq;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, iout, vout, temp;
  int          errors, checked;
  cfec_top #(.FILT_CYC(20), .UNLATCH_CYC(50), .HICCUP_CYC(10)) cfec_top_inst (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .iout_meas_i(iout), .vout_meas_i(vout),
    .temp_meas_i(temp), .primary_enable_pin_i(pri_pin),
    .secondary_enable_pin_i(sec_pin), .stage_run_o(run), .irq_o(irq));
  cfec_onoff_switch cfec_onoff_switch_inst (.closed_i(pri_sw),
    .pin_o(pri_pin));
  cfec_onoff_switch cfec_onoff_switch_sec_inst (.closed_i(sec_sw),
    .pin_o(sec_pin));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic close_out;
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock_i);
    addr <= a; rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    @(negedge clock_i);
    chk(rdata, e);
  endtask : rd
  task automatic wait_run(input logic v);
    int n;
    for (n = 0; n < 600 && run !== v; n++) @(negedge clock_i);
    chk({15'h0, run}, {15'h0, v});
    if (n == 600) close_out();
  endtask : wait_run
  task automatic hold(input logic v, input int c);
    repeat (c) begin
      @(negedge clock_i);
      chk({15'h0, run}, {15'h0, v});
    end
  endtask : hold
  task automatic setp(input logic [15:0] i, v, t, input logic p, s);
    @(posedge clock_i);
    iout <= i; vout <= v; temp <= t; pri_sw <= p; sec_sw <= s;
  endtask : setp
  initial begin
    {rst_i, wr_s, rd_s, addr, wdata} = {3'b100, 4'h0, 16'h0};
    iout = 16'h0;
    vout = 16'h0;
    temp = 16'h0;
    sec_sw = 1'b0;
    errors = 0;
    checked = 0;
    pri_sw = 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`CFEC_ADDR_CTRL, 16'h0000);
    rd(`CFEC_ADDR_OC_THR, `CFEC_OC_THR_RST);
    rd(`CFEC_ADDR_OV_THR, `CFEC_OV_THR_RST);
    rd(`CFEC_ADDR_OT_THR, `CFEC_OT_THR_RST);
    rd(4'h8, 16'h0000);
    wait_run(1'b1);
    setp(0, 0, 0, 0, 0);
    hold(1'b1, 12);
    setp(0, 0, 0, 1, 0);
    hold(1'b1, 40);
    setp(0, 0, 0, 0, 0);
    wait_run(1'b0);
    setp(0, 0, 0, 1, 0);
    wait_run(1'b1);
    wr(`CFEC_ADDR_IRQ_CLR, 16'h000f);
    wr(`CFEC_ADDR_IRQ_EN, 16'h000f);
    setp(16'h02a1, 0, 0, 1, 0);
    wait_run(1'b0);
    wait_run(1'b1);
    wait_run(1'b0);
    rd(`CFEC_ADDR_IRQ_STS, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    wr(`CFEC_ADDR_IRQ_EN, 16'h0000);
    rd(`CFEC_ADDR_IRQ_STS, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    setp(0, 0, 0, 1, 0);
    wait_run(1'b1);
    wr(`CFEC_ADDR_IRQ_CLR, 16'h000f);
    wr(`CFEC_ADDR_IRQ_EN, 16'h000f);
    rd(`CFEC_ADDR_IRQ_STS, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wr(`CFEC_ADDR_CTRL, 16'h0002);
    setp(0, 16'he001, 0, 1, 0);
    wait_run(1'b0);
    setp(0, 0, 0, 1, 0);
    hold(1'b0, 40);
    rd(`CFEC_ADDR_STATUS, 16'h0062);
    setp(0, 0, 0, 0, 0);
    hold(1'b0, 100);
    setp(0, 0, 0, 1, 0);
    wait_run(1'b1);
    setp(0, 0, 16'h01f5, 1, 0);
    wait_run(1'b0);
    hold(1'b0, 30);
    setp(0, 0, 0, 1, 0);
    wait_run(1'b1);
    wr(`CFEC_ADDR_CTRL, 16'h0004);
    setp(0, 0, 16'h01f5, 1, 0);
    wait_run(1'b0);
    setp(0, 0, 0, 1, 0);
    hold(1'b0, 40);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    wait_run(1'b1);
    wr(`CFEC_ADDR_CTRL, 16'h0008);
    wait_run(1'b0);
    setp(0, 0, 0, 0, 1);
    wait_run(1'b1);
    wr(`CFEC_ADDR_CTRL, 16'h0018);
    hold(1'b1, 10);
    setp(0, 0, 0, 0, 0);
    wait_run(1'b0);
    wr(`CFEC_ADDR_CTRL, 16'h0038);
    wait_run(1'b1);
    close_out();
  end
  initial begin
    #200000;
    errors++;
    close_out();
  end
endmodule : tb_converter_fault_enable_ctrl
bind cfec_top cfec_top_checker #(.FILT_CYC(FILT_CYC)) cfec_top_checker_inst (
  .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .irq_o(irq_o),
  .reg_rdata_o(reg_rdata_o), .iout_meas_i(iout_meas_i),
  .stage_run_o(stage_run_o),
  .vout_meas_i(vout_meas_i), .temp_meas_i(temp_meas_i),
  .primary_enable_pin_i(primary_enable_pin_i),
  .secondary_enable_pin_i(secondary_enable_pin_i));
